/* File: src/lhbp_pkg.sv */
// package: constants and types shared by both ends of the lcd host bus port
// Overview of operation
// - device initializes while init input low
// - reset acts on level, held while low
// - transfers only with both chip selects active
// - read-strobe style: device drives bus while read low
// - enable style: read pin becomes enable clock
// - read-strobe style: data latched at write leading edge
// - enable style: write pin becomes direction, high reads
// - strap high parallel, low serial
// - serial mode is write only
package lhbp_pkg;
  localparam int DATA_W      = 8;
  localparam int SER_DATA_BIT = 7;
  localparam int SER_CLK_BIT  = 6;
  localparam int SER_BITS     = 8;
  localparam logic [7:0] RD_DATA_RST = 8'h00;
  // host strobe phases in bus clock cycles
  localparam int STROBE_CYC   = 4;
  typedef logic [DATA_W-1:0] lhbp_byte_type;
endpackage : lhbp_pkg

/* File: src/lhbp_if.sv */
// interface: pins between host and lcd port
`timescale 1ns/1ps
interface lhbp_if;
  logic [7:0] dHost;      // host drive value
  logic [7:0] dHostOeN;   // host enable, low drives
  logic [7:0] dDev;
  logic [7:0] dDevOeN;
  logic       dataCommandSelect;
  logic       initLowInput;
  logic       chipSelectLowN;
  logic       chipSelectHigh;
  logic       rdStrobeN;  // enable clock in enable style
  logic       wrStrobeN;  // direction in enable style
  logic       busStyleSelect;
  logic       parallelSelect;
  modport dev  (input dHost, dHostOeN, dataCommandSelect, initLowInput, chipSelectLowN,
                chipSelectHigh, rdStrobeN, wrStrobeN, busStyleSelect, parallelSelect,
                output dDev, dDevOeN);
  modport host (output dHost, dHostOeN, dataCommandSelect, initLowInput, chipSelectLowN,
                chipSelectHigh, rdStrobeN, wrStrobeN, busStyleSelect, parallelSelect,
                input dDev, dDevOeN);
endinterface : lhbp_if

/* File: src/lhbp_device.sv */
// device end: samples host pins, delivers bytes, answers reads
`timescale 1ns/1ps
module lhbp_device
  import lhbp_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  lhbp_if.dev                      bus,
  output logic                     byteValid,
  output lhbp_pkg::lhbp_byte_type  byteData,
  output logic                     byteIsData,
  input  wire lhbp_pkg::lhbp_byte_type rdData,
  output logic                     rdTaken,
  output logic                     inInit
);
  import lhbp_pkg::*;

  // three-stage synchronisers; decisions use stages two and three only
  localparam int NS = 16;
  logic [NS-1:0] s1Ff, s2Ff, s3Ff, nxt_s1, nxt_s2, nxt_s3;
  logic [NS-1:0] rawIn;
  assign rawIn = {bus.dHost, bus.dataCommandSelect, bus.chipSelectLowN, bus.chipSelectHigh,
                  bus.rdStrobeN, bus.wrStrobeN, bus.initLowInput, bus.parallelSelect,
                  bus.busStyleSelect};
  always_comb
  begin
    nxt_s1 = rawIn;
    nxt_s2 = s1Ff;
    nxt_s3 = s2Ff;
  end
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1Ff <= '0;
      s2Ff <= '0;
      s3Ff <= '0;
    end
    else
    begin
      s1Ff <= nxt_s1;
      s2Ff <= nxt_s2;
      s3Ff <= nxt_s3;
    end
  end

  // filtered pin levels: change only when stages agree
  logic [NS-1:0] pinFf, nxt_pin;
  always_comb
  begin
    nxt_pin = pinFf;
    for (int i = 0; i < NS; i++)
      if (s2Ff[i] == s3Ff[i])
        nxt_pin[i] = s3Ff[i];
  end
  logic [7:0] pD;
  logic pSel, pCsN, pCs, pRd, pWr, pInit;
  // straps share the synchroniser, so mode and strobes move together
  logic parMode, style68;
  assign {pD, pSel, pCsN, pCs, pRd, pWr, pInit, parMode, style68} = pinFf;

  logic chipOn, initOn;
  assign chipOn = !pCsN && pCs;
  assign initOn = !pInit;

  // strobe decode per bus style
  logic wrLead, rdActive, eRise, eFall;
  logic rdPrevFf, wrPrevFf, nxt_rdPrev, nxt_wrPrev;
  assign eRise   = pRd && !rdPrevFf;
  assign eFall   = !pRd && rdPrevFf;
  always_comb
  begin
    if (style68)
    begin
      wrLead   = chipOn && eFall && !pWr;
      rdActive = chipOn && pRd && pWr;
    end
    else
    begin
      wrLead   = chipOn && !pWr && wrPrevFf;
      rdActive = chipOn && !pRd;
    end
  end

  // serial shifter on the two top lines
  logic [7:0] shFf, nxt_sh;
  logic [2:0] cntFf, nxt_cnt;
  logic       sclPrevFf, nxt_sclPrev;
  logic       sclRise;
  assign sclRise = pD[SER_CLK_BIT] && !sclPrevFf;

  logic       vFf, nxt_v, dcFf, nxt_dc, rtFf, nxt_rt;
  lhbp_byte_type bFf, nxt_b, oFf, nxt_o;
  logic [7:0] oeNFf, nxt_oeN;
  always_comb
  begin
    nxt_rdPrev  = pRd;
    nxt_wrPrev  = pWr;
    nxt_sclPrev = pD[SER_CLK_BIT];
    nxt_sh  = shFf;
    nxt_cnt = cntFf;
    nxt_v   = 1'b0;
    nxt_b   = bFf;
    nxt_dc  = dcFf;
    nxt_rt  = 1'b0;
    nxt_o   = oFf;
    nxt_oeN = 8'hff;
    if (initOn)
    begin
      nxt_cnt = '0;
      nxt_sh  = '0;
    end
    else if (parMode)
    begin
      if (wrLead && !rdActive)
      begin
        nxt_v  = 1'b1;
        nxt_b  = pD;
        nxt_dc = pSel;
      end
      if (rdActive)
      begin
        nxt_oeN = 8'h00;
        nxt_o   = rdData;
        nxt_rt  = style68 ? eRise : !wrPrevFf ? 1'b0 : (rdPrevFf && !pRd);
      end
    end
    else if (!chipOn)
      nxt_cnt = '0;
    else if (sclRise)
    begin
      // msb first, select taken with last bit
      nxt_sh  = {shFf[6:0], pD[SER_DATA_BIT]};
      nxt_cnt = cntFf + 3'h1;
      if (cntFf == 3'h7)
      begin
        nxt_v  = 1'b1;
        nxt_b  = {shFf[6:0], pD[SER_DATA_BIT]};
        nxt_dc = pSel;
      end
    end
    // serial mode never drives: lines float, no read path
  end
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pinFf     <= '0;
      rdPrevFf  <= 1'b1;
      wrPrevFf  <= 1'b1;
      sclPrevFf <= 1'b0;
      shFf      <= '0;
      cntFf     <= '0;
      vFf       <= 1'b0;
      bFf       <= '0;
      dcFf      <= 1'b0;
      rtFf      <= 1'b0;
      oFf       <= RD_DATA_RST;
      oeNFf     <= 8'hff;
    end
    else
    begin
      pinFf     <= nxt_pin;
      rdPrevFf  <= nxt_rdPrev;
      wrPrevFf  <= nxt_wrPrev;
      sclPrevFf <= nxt_sclPrev;
      shFf      <= nxt_sh;
      cntFf     <= nxt_cnt;
      vFf       <= nxt_v;
      bFf       <= nxt_b;
      dcFf      <= nxt_dc;
      rtFf      <= nxt_rt;
      oFf       <= nxt_o;
      oeNFf     <= nxt_oeN;
    end
  end

  // init flag registered; level-held reset
  logic initFf, nxt_init;
  always_comb nxt_init = initOn;
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      initFf <= 1'b1;
    else
      initFf <= nxt_init;
  end

  assign byteValid  = vFf;
  assign byteData   = bFf;
  assign byteIsData = dcFf;
  assign rdTaken    = rtFf;
  assign inInit     = initFf;
  assign bus.dDev    = oFf;
  assign bus.dDevOeN = oeNFf;
endmodule : lhbp_device

/* File: src/lhbp_host.sv */
// host end: turns byte requests into parallel or serial pin sequences
`timescale 1ns/1ps
module lhbp_host
  import lhbp_pkg::*;
#(
  parameter int PHASE = STROBE_CYC
)
(
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  lhbp_if.host                         bus,
  input  wire logic                    cfgParallel,
  input  wire logic                    cfgStyle68,
  input  wire logic                    cfgInitLow,
  input  wire logic                    reqValid,
  input  wire logic                    reqRead,
  input  wire logic                    reqIsData,
  input  wire lhbp_pkg::lhbp_byte_type reqData,
  output logic                         reqReady,
  output logic                         rspValid,
  output lhbp_pkg::lhbp_byte_type      rspData
);
  import lhbp_pkg::*;

  typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_SLOW, ST_SHIGH} lhbp_st_type;
  lhbp_st_type stFf, nxt_st;
  logic [7:0] phFf, nxt_ph;
  logic [2:0] bitFf, nxt_bit;
  logic rdFf, nxt_rd, selFf, nxt_sel, rdyFf, nxt_rdy, rvFf, nxt_rv;
  lhbp_byte_type dFf, nxt_d, rsFf, nxt_rs;
  logic csFf, nxt_cs, strFf, nxt_str, dirFf, nxt_dir, sclFf, nxt_scl;
  logic phEnd;
  assign phEnd = (phFf == 8'(PHASE - 1));

  // sequencer: setup, strobe, hold per byte; eight clocks per serial byte
  always_comb
  begin
    nxt_st = stFf; nxt_ph = phEnd ? 8'h00 : phFf + 8'h01;
    nxt_bit = bitFf; nxt_rd = rdFf; nxt_sel = selFf; nxt_d = dFf;
    nxt_rdy = 1'b0; nxt_rv = 1'b0; nxt_rs = rsFf;
    nxt_cs = csFf; nxt_str = strFf; nxt_dir = dirFf; nxt_scl = sclFf;
    case (stFf)
      ST_IDLE:
      begin
        nxt_ph = '0; nxt_rdy = !cfgInitLow;
        if (reqValid && rdyFf)
        begin
          nxt_rdy = 1'b0; nxt_d = reqData; nxt_sel = reqIsData;
          nxt_rd = reqRead && cfgParallel;
          nxt_cs = 1'b1; nxt_bit = '0;
          nxt_dir = reqRead && cfgParallel;
          nxt_st = cfgParallel ? ST_SETUP : ST_SLOW;
        end
      end
      ST_SETUP: if (phEnd) begin nxt_str = 1'b1; nxt_st = ST_STROBE; end
      ST_STROBE:
        if (phEnd)
        begin
          nxt_str = 1'b0;
          nxt_st  = ST_HOLD;
        end
      // device answers through its pin synchroniser, so read data is taken late
      ST_HOLD:
        if (phEnd)
        begin
          nxt_cs = 1'b0;
          nxt_st = ST_IDLE;
          if (rdFf)
          begin
            nxt_rs = bus.dDev;
            nxt_rv = 1'b1;
          end
        end
      ST_SLOW: if (phEnd) begin nxt_scl = 1'b1; nxt_st = ST_SHIGH; end
      ST_SHIGH:
        if (phEnd)
        begin
          nxt_scl = 1'b0; nxt_bit = bitFf + 3'h1;
          nxt_d = {dFf[6:0], 1'b0};
          if (bitFf == 3'h7) begin nxt_cs = 1'b0; nxt_st = ST_IDLE; end
          else nxt_st = ST_SLOW;
        end
      default: nxt_st = ST_IDLE;
    endcase
  end
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stFf <= ST_IDLE; phFf <= '0; bitFf <= '0; rdFf <= 1'b0; selFf <= 1'b0;
      dFf <= '0; rdyFf <= 1'b0; rvFf <= 1'b0; rsFf <= '0; csFf <= 1'b0;
      strFf <= 1'b0; dirFf <= 1'b0; sclFf <= 1'b0;
    end
    else
    begin
      stFf <= nxt_st; phFf <= nxt_ph; bitFf <= nxt_bit; rdFf <= nxt_rd; selFf <= nxt_sel;
      dFf <= nxt_d; rdyFf <= nxt_rdy; rvFf <= nxt_rv; rsFf <= nxt_rs; csFf <= nxt_cs;
      strFf <= nxt_str; dirFf <= nxt_dir; sclFf <= nxt_scl;
    end
  end

  // pin mapping per mode and style
  always_comb
  begin
    bus.chipSelectLowN    = !csFf;
    bus.chipSelectHigh    = csFf;
    bus.dataCommandSelect = selFf;
    bus.initLowInput      = !cfgInitLow;
    bus.busStyleSelect    = cfgStyle68;
    bus.parallelSelect    = cfgParallel;
    bus.dHost             = dFf;
    bus.dHostOeN          = rdFf ? 8'hff : 8'h00;
    if (!cfgParallel)
    begin
      bus.dHost    = {dFf[7], sclFf, 6'h00};
      bus.dHostOeN = 8'h3f;
      bus.rdStrobeN = 1'b1; bus.wrStrobeN = 1'b1;
    end
    else if (cfgStyle68)
    begin
      bus.rdStrobeN = strFf;                                       // enable high
      bus.wrStrobeN = dirFf;
    end
    else
    begin
      bus.rdStrobeN = !(strFf && rdFf);
      bus.wrStrobeN = !(strFf && !rdFf);
    end
  end

  assign reqReady = rdyFf;
  assign rspValid = rvFf;
  assign rspData  = rsFf;
endmodule : lhbp_host

/* File: bench/lhbp_asserts.sv */
// checker on the pins between host and device ends
`timescale 1ns/1ps
module lhbp_asserts (
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic [7:0] dHost,
  input wire logic [7:0] dHostOeN,
  input wire logic [7:0] dDevOeN,
  input wire logic       dataCommandSelect,
  input wire logic       initLowInput,
  input wire logic       chipSelectLowN,
  input wire logic       chipSelectHigh,
  input wire logic       rdStrobeN,
  input wire logic       wrStrobeN,
  input wire logic       busStyleSelect,
  input wire logic       parallelSelect
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // both selects active
  wire logic chipOn = !chipSelectLowN && chipSelectHigh;
  a_serial_no_drive: assert property (!parallelSelect |-> dDevOeN == 8'hff)
    else $error("device drives bus in serial mode");
  a_read80_drives: assert property ($fell(rdStrobeN) && chipOn && parallelSelect
    && !busStyleSelect |-> ##[1:8] dDevOeN == 8'h00)
    else $error("no bus drive during read strobe");
  a_write_span: assert property ($fell(wrStrobeN) && parallelSelect && !busStyleSelect
    |-> chipOn throughout (!wrStrobeN)[*4])
    else $error("write strobe short or chip not selected");
  a_enable_span: assert property ($rose(rdStrobeN) && parallelSelect && busStyleSelect
    |-> chipOn throughout rdStrobeN[*4])
    else $error("enable pulse short or chip not selected");
  a_read68_drives: assert property ($rose(rdStrobeN) && wrStrobeN && busStyleSelect
    && parallelSelect |-> ##[1:8] dDevOeN == 8'h00)
    else $error("no bus drive on direction read");
  a_init_quiet: assert property (!initLowInput |-> !chipOn)
    else $error("chip selected during init");
  a_sclk_frame: assert property ($rose(dHost[6]) && !parallelSelect
    |-> chipOn && dHostOeN[7:6] == 2'b00 && $stable(dHost[7]))
    else $error("serial clock edge outside frame or data moving");
  a_dc_steady: assert property (chipOn && !wrStrobeN && parallelSelect && !busStyleSelect
    |-> $stable(dataCommandSelect))
    else $error("data select moved in write strobe");
endmodule : lhbp_asserts

/* File: bench/testbench.sv */
// bench: host requests in, device bytes and read answers checked
`timescale 1ns/1ps
module testbench;
  import lhbp_pkg::*;
  logic          mclk = 1'b0;
  logic          sys_rst = 1'b1;
  logic          cfgParallel = 1'b1;
  logic          cfgStyle68 = 1'b0;
  logic          cfgInitLow = 1'b0;
  logic          reqValid = 1'b0;
  logic          reqRead = 1'b0;
  logic          reqIsData = 1'b0;
  lhbp_byte_type reqData = 8'h00;
  lhbp_byte_type rdData = 8'h00;
  lhbp_byte_type byteData;
  lhbp_byte_type rspData;
  logic          reqReady;
  logic          rspValid;
  logic          byteValid;
  logic          byteIsData;
  logic          rdTaken;
  logic          inInit;
  logic [8:0]    devQ[$];
  logic [8:0]    rspQ[$];
  int            n_fail = 0;
  int            checks = 0;
  int            nReads = 0;
  int            nTaken = 0;
  lhbp_if bus();
  lhbp_host u_lhbp_host (.mclk, .sys_rst, .bus(bus.host), .cfgParallel, .cfgStyle68,
    .cfgInitLow, .reqValid, .reqRead, .reqIsData, .reqData, .reqReady, .rspValid, .rspData);
  lhbp_device u_lhbp_device (.mclk, .sys_rst, .bus(bus.dev), .byteValid, .byteData,
    .byteIsData, .rdData, .rdTaken, .inInit);
  lhbp_asserts u_lhbp_asserts (.mclk, .sys_rst, .dHost(bus.dHost), .dHostOeN(bus.dHostOeN),
    .dDevOeN(bus.dDevOeN), .dataCommandSelect(bus.dataCommandSelect),
    .initLowInput(bus.initLowInput), .chipSelectLowN(bus.chipSelectLowN),
    .chipSelectHigh(bus.chipSelectHigh), .rdStrobeN(bus.rdStrobeN),
    .wrStrobeN(bus.wrStrobeN), .busStyleSelect(bus.busStyleSelect),
    .parallelSelect(bus.parallelSelect));
  // free-running bus clock
  always #4 mclk = ~mclk;
  task automatic fail(input logic [8:0] got, input logic [8:0] exp);
    n_fail++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
  endtask : fail
  task automatic close_out;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  // bounded wait on a settled flag; a timeout ends the run
  task automatic wait_for(ref logic flag, input logic lvl);
    int i;
    // step off the edge so the flag is settled
    #1;
    for (i = 0; i < 400 && flag !== lvl; i++)
    begin
      @(posedge mclk);
      #1;
    end
    checks++;
    if (flag !== lvl)
    begin
      fail({8'h00, flag}, {8'h00, lvl});
      close_out;
    end
  endtask : wait_for
  // one request; the note is queued before the pins move
  task automatic xfer(input logic par, input logic s68, input logic rd, input logic dc);
    lhbp_byte_type d;
    lhbp_byte_type r;
    int k;
    d = $urandom;
    r = $urandom;
    wait_for(reqReady, 1'b1);
    @(posedge mclk);
    cfgParallel <= par;
    cfgStyle68 <= s68;
    rdData <= r;
    if (rd && par)
    begin
      rspQ.push_back({1'b0, r});
      nReads++;
    end
    else
      devQ.push_back({dc, d});
    @(posedge mclk);
    reqValid <= 1'b1;
    reqRead <= rd;
    reqIsData <= dc;
    reqData <= d;
    // request stands until an edge samples ready high
    @(posedge mclk);
    for (k = 0; k < 400 && reqReady !== 1'b1; k++)
      @(posedge mclk);
    reqValid <= 1'b0;
    checks++;
    if (reqReady !== 1'b1)
    begin
      fail({8'h00, reqReady}, 9'h001);
      close_out;
    end
  endtask : xfer
  // result side: each output event takes the oldest note
  always @(posedge mclk)
  begin
    #1;
    if (byteValid === 1'b1)
    begin
      checks++;
      if (devQ.size() == 0)
        fail({byteIsData, byteData}, 9'h1ff);
      else if ({byteIsData, byteData} !== devQ[0])
        fail({byteIsData, byteData}, devQ[0]);
      if (devQ.size() != 0)
        void'(devQ.pop_front());
    end
    if (rspValid === 1'b1)
    begin
      checks++;
      if (rspQ.size() == 0)
        fail({1'b0, rspData}, 9'h1ff);
      else if ({1'b0, rspData} !== rspQ[0])
        fail({1'b0, rspData}, rspQ[0]);
      if (rspQ.size() != 0)
        void'(rspQ.pop_front());
    end
    // one read-taken pulse per parallel read
    if (rdTaken === 1'b1)
      nTaken++;
  end
  // main sequence: both parallel bus styles, then serial mode, then init hold
  initial
  begin
    int m;
    int i;
    void'($urandom(32'he7648c9a));
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    for (m = 0; m < 3; m++)
    begin
      for (i = 0; i < 6; i++)
        xfer(m < 2, m == 1, i[0], i[1]);
      $display("test style %0d done", m);
    end
    wait_for(reqReady, 1'b1);
    @(posedge mclk);
    cfgInitLow <= 1'b1;
    wait_for(inInit, 1'b1);
    repeat (40) @(posedge mclk);
    #1;
    wait_for(inInit, 1'b1);
    wait_for(reqReady, 1'b0);
    @(posedge mclk);
    cfgInitLow <= 1'b0;
    wait_for(inInit, 1'b0);
    xfer(1'b1, 1'b0, 1'b0, 1'b1);
    // strobe edges while deselected must yield no byte
    wait_for(reqReady, 1'b1);
    for (i = 0; i < 4; i++)
    begin
      @(posedge mclk);
      cfgStyle68 <= !cfgStyle68;
      repeat (12) @(posedge mclk);
    end
    $display("test init done");
    for (i = 0; i < 400 && devQ.size() + rspQ.size() != 0; i++)
      @(posedge mclk);
    if (devQ.size() + rspQ.size() != 0)
      fail(9'h000, 9'h001);
    checks++;
    if (nTaken != nReads)
      fail(nTaken[8:0], nReads[8:0]);
    close_out;
  end
endmodule : testbench
